// >>> design/rfc_pkg.sv
// Constants and types shared by the chip function control block
package rfc_pkg;

  // Register map
  localparam logic [7:0] FUNC_CTRL_ADDR = 8'h28;
  localparam logic [7:0] FUNC_CTRL_RESET = 8'h00;

  // Field positions inside chip_function_control
  localparam int HUNDREDTHS_BIT = 7;
  localparam int PERIODIC_MSB = 6;
  localparam int PERIODIC_LSB = 5;
  localparam int COUNT_MODE_BIT = 4;
  localparam int STOP_SOURCE_BIT = 3;
  localparam int CLKOUT_MSB = 2;
  localparam int CLKOUT_LSB = 0;

  // Periodic interrupt selections
  localparam logic [1:0] PERIODIC_NONE = 2'h0;
  localparam logic [1:0] PERIODIC_SECOND = 2'h1;
  localparam logic [1:0] PERIODIC_MINUTE = 2'h2;
  localparam logic [1:0] PERIODIC_HOUR = 2'h3;

  // Clock output selections
  localparam logic [2:0] CLKOUT_32768 = 3'h0;
  localparam logic [2:0] CLKOUT_16384 = 3'h1;
  localparam logic [2:0] CLKOUT_8192 = 3'h2;
  localparam logic [2:0] CLKOUT_4096 = 3'h3;
  localparam logic [2:0] CLKOUT_2048 = 3'h4;
  localparam logic [2:0] CLKOUT_1024 = 3'h5;
  localparam logic [2:0] CLKOUT_1HZ = 3'h6;
  localparam logic [2:0] CLKOUT_STATIC = 3'h7;

  // Stamp pin and interrupt-A pin modes
  localparam logic [1:0] STAMP_MODE_CLKOUT = 2'h2;
  localparam logic [1:0] STAMP_MODE_INPUT = 2'h3;
  localparam logic [1:0] IRQ_A_MODE_CLKOUT = 2'h0;

  // Oscillator prescaler: 32768 ticks per second
  localparam int PRESCALE_W = 15;
  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 15'h7fff;
  localparam logic [6:0] TICK_256_LAST = 7'h7f;
  localparam int ONE_HZ_BIT = 14;

  // Fractional 256 Hz to 100 Hz divider
  localparam logic [1:0] DIV3_LAST = 2'h2;
  localparam logic [1:0] DIV2_LAST = 2'h1;
  localparam logic [3:0] DIV3_RUNS_LAST = 4'hd;
  localparam logic [3:0] DIV2_RUNS_LAST = 4'ha;
  localparam logic [6:0] HUNDREDTHS_LAST = 7'h63;

  // Periodic timers, in seconds
  localparam logic [5:0] MINUTE_LAST = 6'h3b;
  localparam logic [11:0] HOUR_LAST = 12'he0f;

  typedef enum logic {RFC_PH_DIV3, RFC_PH_DIV2} rfc_phase_t;

endpackage

// >>> design/rfc_function_control.sv
// Chip function control: resolution, periodic timers, stop, clock output
// Notes on behaviour
// - Bit 7 set enables hundredths register and 0.01 s time steps.
// - 100 Hz tick from 256 Hz: divide by 3 fourteen times, 2 eleven.
// - Bits 6:5 pick periodic interval: none, second, minute, hour.
// - Disabled timers held in reset; first pulse within one period.
// - Periodic timers keep running while time counting is halted.
// - Every periodic trigger sets the periodic interrupt flag.
// - Further periodic pulses issue even if the flag is still set.
// - Offset calibration never changes periodic pulse duration.
// - Bit 4 picks calendar counting or stop-watch counting up to hours.
// - The oscillator stop bit halts counting in both counting modes.
// - Bit 3 set lets stop bit or active stamp pin halt counting.
// - Bits 2:0 select 32768 Hz down to 1 Hz, or static/released pins.
// - Clock pin is push-pull, on at reset, driven low when disabled.
// - Selected clock can also reach stamp pin and interrupt-A pin.
// - Invert bit inverts clock output except for selection 111.
// - Divided clock outputs have 50:50 duty; 32768 Hz may deviate.
// - 1 Hz clock output is not altered by offset correction.
// - Stamp event is rising edge active high, falling edge active low.
// - Interrupt-A clock is open-drain active low, released on battery.
`timescale 1ns/1ps
`default_nettype none

module rfc_function_control
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_soft_reset,
  input wire logic i_osc_clk,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_stop_bit,
  input wire logic i_stamp_pin_polarity,
  input wire logic [1:0] i_stamp_pin_mode,
  input wire logic [1:0] i_irq_a_pin_mode,
  input wire logic i_clock_pin_disable,
  input wire logic i_clock_output_invert,
  input wire logic i_on_battery,
  input wire logic i_stamp_pin,
  output logic o_hundredths_mode_en,
  output logic o_count_mode_sel,
  output logic [6:0] o_hundredths,
  output logic o_hundredths_tick,
  output logic o_second_tick,
  output logic o_count_halted,
  output logic o_stamp_event,
  output logic o_periodic_pulse,
  output logic o_periodic_irq_flag_set,
  output logic o_clk_pin,
  output logic o_stamp_pin_out,
  output logic o_stamp_pin_oe,
  output logic o_irq_a_pin_out,
  output logic o_irq_a_pin_oe
);

  logic [7:0] cfg_q;
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic stamp_s1_q, stamp_s2_q, stamp_s3_q;
  logic [rfc_pkg::PRESCALE_W-1:0] prescale_q;
  rfc_pkg::rfc_phase_t phase_q;
  logic [1:0] sub_q;
  logic [3:0] run_q;
  logic hund_tick_q;
  logic [6:0] hund_q;
  logic [5:0] min_cnt_q;
  logic [11:0] hour_cnt_q;
  logic periodic_q;
  logic halt_q;
  logic event_q;
  logic sec_tick_q;
  logic [7:0] rdata_q;
  logic clk_pin_q, stamp_out_q, stamp_oe_q, irq_a_oe_q;
  logic osc_tick, sec_wrap, tick_256, halt_d, clk_raw, clk_sel;
  logic [1:0] periodic_sel;
  logic [2:0] clkout_sel;

  // Level of the stamp pin that counts as active for the chosen polarity
  function automatic logic stamp_active(input logic level, input logic pol);
    stamp_active = pol ? ~level : level;
  endfunction

  assign periodic_sel = cfg_q[rfc_pkg::PERIODIC_MSB:rfc_pkg::PERIODIC_LSB];
  assign clkout_sel = cfg_q[rfc_pkg::CLKOUT_MSB:rfc_pkg::CLKOUT_LSB];

  //////////////////////////////////////////////////////////////////////////
  // Register access

  // Control register; both resets clear every field
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || i_soft_reset)
      cfg_q <= rfc_pkg::FUNC_CTRL_RESET;
    else if (i_reg_wr && i_reg_addr == rfc_pkg::FUNC_CTRL_ADDR)
      cfg_q <= i_reg_wdata;
  end

  // Read data follows the address one cycle later; other addresses read 0
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      rdata_q <= 8'h00;
    else if (i_reg_addr == rfc_pkg::FUNC_CTRL_ADDR)
      rdata_q <= cfg_q;
    else
      rdata_q <= 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Oscillator arrives from outside the core clock domain
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end
    else
    begin
      osc_s1_q <= i_osc_clk;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // Stamp pin keeps sampling through reset: a pin idling high gives no
  // false active edge when reset lets go
  always_ff @(posedge i_core_clk)
  begin
    stamp_s1_q <= i_stamp_pin;
    stamp_s2_q <= stamp_s1_q;
    stamp_s3_q <= stamp_s2_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // Prescaler and hundredths divider

  assign osc_tick = osc_s2_q & ~osc_s3_q;
  assign sec_wrap = osc_tick && prescale_q == rfc_pkg::PRESCALE_LAST;
  assign tick_256 = osc_tick && prescale_q[6:0] == rfc_pkg::TICK_256_LAST;

  // Free running so periodic timers and clock output never see the stop
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      prescale_q <= '0;
    else if (osc_tick)
      prescale_q <= prescale_q + 1'b1;
  end

  // 64 ticks of 256 Hz make 25 hundredths: 14 by three, then 11 by two
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      phase_q <= rfc_pkg::RFC_PH_DIV3;
      sub_q <= 2'h0;
      run_q <= 4'h0;
      hund_tick_q <= 1'b0;
    end
    else
    begin
      hund_tick_q <= 1'b0;
      if (tick_256)
      begin
        case (phase_q)
          rfc_pkg::RFC_PH_DIV3:
          begin
            sub_q <= (sub_q == rfc_pkg::DIV3_LAST) ? 2'h0 : sub_q + 1'b1;
            if (sub_q == rfc_pkg::DIV3_LAST)
            begin
              hund_tick_q <= 1'b1;
              run_q <= (run_q == rfc_pkg::DIV3_RUNS_LAST) ? 4'h0
                                                         : run_q + 1'b1;
              if (run_q == rfc_pkg::DIV3_RUNS_LAST)
                phase_q <= rfc_pkg::RFC_PH_DIV2;
            end
          end
          rfc_pkg::RFC_PH_DIV2:
          begin
            sub_q <= (sub_q == rfc_pkg::DIV2_LAST) ? 2'h0 : sub_q + 1'b1;
            if (sub_q == rfc_pkg::DIV2_LAST)
            begin
              hund_tick_q <= 1'b1;
              run_q <= (run_q == rfc_pkg::DIV2_RUNS_LAST) ? 4'h0
                                                         : run_q + 1'b1;
              if (run_q == rfc_pkg::DIV2_RUNS_LAST)
                phase_q <= rfc_pkg::RFC_PH_DIV3;
            end
          end
          default:
            phase_q <= rfc_pkg::RFC_PH_DIV3;
        endcase
      end
    end
  end

  // Hundredths register; frozen while halted, zero when resolution is 1 s
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || !cfg_q[rfc_pkg::HUNDREDTHS_BIT])
      hund_q <= 7'h00;
    else if (hund_tick_q && !halt_q)
      hund_q <= (hund_q == rfc_pkg::HUNDREDTHS_LAST) ? 7'h00
                                                     : hund_q + 1'b1;
  end

  // Seconds step to the counters; suppressed while halted
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      sec_tick_q <= 1'b0;
    else
      sec_tick_q <= sec_wrap && !halt_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // Periodic interrupt timers

  // Held cleared while disabled so the first pulse lands inside one period
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || periodic_sel == rfc_pkg::PERIODIC_NONE)
    begin
      min_cnt_q <= 6'h00;
      hour_cnt_q <= 12'h000;
    end
    else if (sec_wrap)
    begin
      min_cnt_q <= (min_cnt_q == rfc_pkg::MINUTE_LAST) ? 6'h00
                                                       : min_cnt_q + 1'b1;
      hour_cnt_q <= (hour_cnt_q == rfc_pkg::HOUR_LAST) ? 12'h000
                                                       : hour_cnt_q + 1'b1;
    end
  end

  // One core-cycle pulse; the flag state is not consulted
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      periodic_q <= 1'b0;
    else
      case (periodic_sel)
        rfc_pkg::PERIODIC_SECOND: periodic_q <= sec_wrap;
        rfc_pkg::PERIODIC_MINUTE:
          periodic_q <= sec_wrap && min_cnt_q == rfc_pkg::MINUTE_LAST;
        rfc_pkg::PERIODIC_HOUR:
          periodic_q <= sec_wrap && hour_cnt_q == rfc_pkg::HOUR_LAST;
        default: periodic_q <= 1'b0;
      endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Stop control and stamp edge

  // Stop bit wins; the pin only counts in input mode with pin stop chosen
  assign halt_d = i_stop_bit
    || (cfg_q[rfc_pkg::STOP_SOURCE_BIT]
        && i_stamp_pin_mode == rfc_pkg::STAMP_MODE_INPUT
        && stamp_active(stamp_s2_q, i_stamp_pin_polarity));

  // Halt state and active stamp transition
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      halt_q <= 1'b0;
      event_q <= 1'b0;
    end
    else
    begin
      halt_q <= halt_d;
      event_q <= i_stamp_pin_mode == rfc_pkg::STAMP_MODE_INPUT
        && stamp_active(stamp_s2_q, i_stamp_pin_polarity)
        && !stamp_active(stamp_s3_q, i_stamp_pin_polarity);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock output

  // Divided rates are prescaler bits, hence exact 50:50 duty
  always_comb
  begin
    case (clkout_sel)
      rfc_pkg::CLKOUT_32768: clk_raw = osc_s2_q;
      rfc_pkg::CLKOUT_16384: clk_raw = prescale_q[0];
      rfc_pkg::CLKOUT_8192: clk_raw = prescale_q[1];
      rfc_pkg::CLKOUT_4096: clk_raw = prescale_q[2];
      rfc_pkg::CLKOUT_2048: clk_raw = prescale_q[3];
      rfc_pkg::CLKOUT_1024: clk_raw = prescale_q[4];
      rfc_pkg::CLKOUT_1HZ: clk_raw = prescale_q[rfc_pkg::ONE_HZ_BIT];
      default: clk_raw = 1'b0;
    endcase
  end

  // Static selection is never inverted
  assign clk_sel = (clkout_sel == rfc_pkg::CLKOUT_STATIC) ? 1'b0
                 : clk_raw ^ i_clock_output_invert;

  // Three pin drivers; stamp and interrupt-A pins release on battery
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      clk_pin_q <= 1'b0;
      stamp_out_q <= 1'b0;
      stamp_oe_q <= 1'b0;
      irq_a_oe_q <= 1'b0;
    end
    else
    begin
      clk_pin_q <= !i_clock_pin_disable && clk_sel;
      stamp_out_q <= clk_sel;
      stamp_oe_q <= i_stamp_pin_mode == rfc_pkg::STAMP_MODE_CLKOUT
                    && !i_on_battery;
      irq_a_oe_q <= i_irq_a_pin_mode == rfc_pkg::IRQ_A_MODE_CLKOUT
                    && clkout_sel != rfc_pkg::CLKOUT_STATIC
                    && !i_on_battery && !clk_sel;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_hundredths_mode_en = cfg_q[rfc_pkg::HUNDREDTHS_BIT];
  assign o_count_mode_sel = cfg_q[rfc_pkg::COUNT_MODE_BIT];
  assign o_hundredths = hund_q;
  assign o_hundredths_tick = hund_tick_q && !halt_q
                             && cfg_q[rfc_pkg::HUNDREDTHS_BIT];
  assign o_second_tick = sec_tick_q;
  assign o_count_halted = halt_q;
  assign o_stamp_event = event_q;
  assign o_periodic_pulse = periodic_q;
  assign o_periodic_irq_flag_set = periodic_q;
  assign o_clk_pin = clk_pin_q;
  assign o_stamp_pin_out = stamp_out_q;
  assign o_stamp_pin_oe = stamp_oe_q;
  assign o_irq_a_pin_out = 1'b0;
  assign o_irq_a_pin_oe = irq_a_oe_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  a_soft_reset_cfg: assert property (i_soft_reset |=> cfg_q == 8'h00)
    else $error("soft reset did not clear control register");
  a_hund_needs_mode: assert property (!cfg_q[rfc_pkg::HUNDREDTHS_BIT]
    |=> hund_q == 7'h00)
    else $error("hundredths counted with mode off");
  a_div_aligned: assert property (sec_wrap |=> hund_tick_q
    && phase_q == rfc_pkg::RFC_PH_DIV3 && run_q == 4'h0)
    else $error("hundredths divider out of step with second");
  a_periodic_off: assert property (periodic_sel == 2'h0 |=>
    min_cnt_q == 6'h00 && hour_cnt_q == 12'h000 && !periodic_q)
    else $error("periodic timer active while disabled");
  a_second_pulse: assert property (periodic_sel == 2'h1 && sec_wrap
    && $stable(cfg_q) |=> periodic_q)
    else $error("per-second pulse missing");
  a_pulse_while_halt: assert property (halt_q && periodic_sel == 2'h2
    && sec_wrap && min_cnt_q == 6'h3b |=> periodic_q)
    else $error("minute pulse blocked by halt");
  a_flag_with_pulse: assert property (o_periodic_pulse
    == o_periodic_irq_flag_set)
    else $error("flag set not paired with pulse");
  a_stop_bit_halts: assert property (i_stop_bit |=> halt_q
    && !o_second_tick)
    else $error("stop bit did not halt counting");
  a_pin_halts: assert property (!i_stop_bit
    && cfg_q[rfc_pkg::STOP_SOURCE_BIT] && i_stamp_pin_mode == 2'h3
    && stamp_s2_q != i_stamp_pin_polarity |=> halt_q)
    else $error("active stamp pin did not halt counting");
  a_clk_pin_off: assert property (i_clock_pin_disable |=> !o_clk_pin)
    else $error("disabled clock pin not low");
  a_static_out: assert property (clkout_sel == 3'h7
    |=> !o_irq_a_pin_oe && (!o_clk_pin || $changed(cfg_q)))
    else $error("static selection still toggling");

  c_minute_pulse: cover property (periodic_sel == 2'h2 && periodic_q);
  c_hund_wrap: cover property (hund_q == 7'h63 && hund_tick_q);
  c_stamp_event: cover property (o_stamp_event);
  c_pin_halt: cover property (halt_q && !i_stop_bit);

endmodule

`default_nettype wire

// >>> testbench/rfc_osc_model.sv
// Oscillator partner model for the chip function control bench
`timescale 1ns/1ps
`default_nettype none

module rfc_osc_model
(
  input wire logic i_core_clk,
  output logic o_osc_clk
);
  // Two core cycles per tick: fastest the two-flop sync still follows
  initial o_osc_clk = 1'b0;
  always @(negedge i_core_clk)
    o_osc_clk <= ~o_osc_clk;
endmodule

`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the chip function control block
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk, rst, srst, osc, wr, stop, pol, cpd, inv, batt, pin;
  logic [7:0] addr, wdata, rdata, r, v;
  logic [1:0] smode, amode;
  logic hen, cms, htick, stick, halted, sev, pp, pflag;
  logic cpin, sout, soe, aout, aoe;
  logic [6:0] hund;
  int mismatches, check_count, n_s, n_ev, n_p, n_fl, cyc, last_h, last_p;
  int hi, lo, bad, sum, g0, h0, s0, p0, e0, en_cyc;
  int gaps[$];
  int hv[$];

  ////////////////////////////////////////////////////////////////////////////
  rfc_osc_model osc_src (.i_core_clk(clk), .o_osc_clk(osc));

  rfc_function_control dut (.i_core_clk(clk), .i_reset(rst),
    .i_soft_reset(srst), .i_osc_clk(osc), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_stop_bit(stop), .i_stamp_pin_polarity(pol),
    .i_stamp_pin_mode(smode), .i_irq_a_pin_mode(amode),
    .i_clock_pin_disable(cpd), .i_clock_output_invert(inv),
    .i_on_battery(batt), .i_stamp_pin(pin), .o_hundredths_mode_en(hen),
    .o_count_mode_sel(cms), .o_hundredths(hund), .o_hundredths_tick(htick),
    .o_second_tick(stick), .o_count_halted(halted), .o_stamp_event(sev),
    .o_periodic_pulse(pp), .o_periodic_irq_flag_set(pflag),
    .o_clk_pin(cpin), .o_stamp_pin_out(sout), .o_stamp_pin_oe(soe),
    .o_irq_a_pin_out(aout), .o_irq_a_pin_oe(aoe));

  // 40 MHz core clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // Pulse bookkeeping, taken mid-cycle where pulses are settled
  always @(negedge clk)
  begin
    cyc++;
    if (htick === 1'b1)
    begin
      gaps.push_back(cyc - last_h);
      hv.push_back(int'(hund));
      last_h = cyc;
    end
    n_s += int'(stick === 1'b1);
    n_ev += int'(sev === 1'b1);
    n_p += int'(pp === 1'b1);
    if (pp === 1'b1)
      last_p = cyc;
    n_fl += int'(pflag !== pp);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp,
    input string what);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp, input string what);
    check_count++;
    if (got != exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Called at a falling edge; strobe stands for exactly one rising edge,
  // then one idle edge so back-to-back calls never glitch the strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    tick(2);
    d = rdata;
  endtask

  // High and low time of the clock pin, in core cycles, bounded
  task automatic measure(output int h, output int l);
    h = 0;
    l = 0;
    for (int k = 0; k < 300 && cpin !== 1'b0; k++)
      @(negedge clk);
    for (int k = 0; k < 300 && cpin !== 1'b1; k++)
      @(negedge clk);
    for (int k = 0; k < 300 && cpin === 1'b1; k++)
      h++;
    for (int k = 0; k < 300 && cpin === 1'b1; k++)
      @(negedge clk);
    h = 0;
    while (cpin === 1'b0 && l < 300)
    begin
      @(negedge clk);
      l++;
    end
    while (cpin === 1'b1 && h < 300)
    begin
      @(negedge clk);
      h++;
    end
  endtask

  task automatic end_sim();
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: whole run is about 66k cycles
  initial
  begin
    repeat (100000) @(negedge clk);
    mismatches++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'hf3bf43b0));
    {rst, srst, wr, stop, pol, cpd, inv, batt, pin} = 9'h100;
    {addr, wdata, smode, amode} = 20'h0;
    tick(3);
    rst = 1'b0;
    rd_reg(8'h28, r);
    chk_val(r, 8'h00, "reset value");
    // Random read-back; unmapped place neither stores nor reads back
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom);
      wr_reg(8'h28, v);
      wr_reg(8'h29, ~v);
      rd_reg(8'h28, r);
      chk_val(r, v, "readback");
      chk_val({6'h0, hen, cms}, {6'h0, v[7], v[4]}, "modes");
      rd_reg(8'h29, r);
      chk_val(r, 8'h00, "unmapped read");
    end
    srst = 1'b1;
    tick(1);
    srst = 1'b0;
    rd_reg(8'h28, r);
    chk_val(r, 8'h00, "soft reset");
    // Divided clocks: half period is 2**sel core cycles here
    smode = 2'h2;
    for (int s = 1; s < 6; s++)
    begin
      inv = 1'($urandom);
      wr_reg(8'h28, 8'(s));
      tick(4);
      measure(hi, lo);
      chk_cnt(hi, 1 << s, "clock high");
      chk_cnt(lo, 1 << s, "clock low");
      v = {4'h0, 1'b0, cpin, 1'b1, ~cpin};
      chk_val({4'h0, aout, sout, soe, aoe}, v, "pins");
    end
    batt = 1'b1;
    tick(3);
    chk_val({6'h0, soe, aoe}, 8'h00, "battery release");
    batt = 1'b0;
    inv = 1'b1;
    wr_reg(8'h28, 8'h07);
    tick(3);
    chk_val({4'h0, cpin, sout, soe, aoe}, 8'h02, "static");
    // Disabled clock pin stays low across several toggles
    wr_reg(8'h28, 8'h01);
    cpd = 1'b1;
    tick(3);
    r = 8'h00;
    repeat (6)
    begin
      tick(1);
      r[0] = r[0] | cpin;
    end
    chk_val(r, 8'h00, "clock pin disabled");
    cpd = 1'b0;
    // Stop sources; pin configured as input before use
    smode = 2'h3;
    for (int k = 0; k < 16; k++)
    begin
      {stop, pol, pin} = 3'(k);
      wr_reg(8'h28, {4'h0, 1'(k >> 3), 3'h7});
      tick(5);
      v = {7'h0, stop | (1'(k >> 3) & (pin ^ pol))};
      chk_val({7'h0, halted}, v, "halt");
    end
    stop = 1'b0;
    // One event per active transition, none on the inactive one
    for (int k = 0; k < 2; k++)
    begin
      pol = 1'(k);
      pin = 1'(k);
      tick(6);
      e0 = n_ev;
      pin = ~pin;
      tick(6);
      pin = ~pin;
      tick(6);
      chk_cnt(n_ev - e0, 1, "stamp event");
    end
    chk_cnt(n_p, 0, "no periodic");
    // Hundredths pacing over two full 25-step cycles
    smode = 2'h0;
    wr_reg(8'h28, 8'ha6);
    en_cyc = cyc;
    g0 = gaps.size();
    for (int k = 0; k < 40000 && gaps.size() < g0 + 52; k++)
      @(negedge clk);
    chk_cnt(int'(gaps.size() >= g0 + 52), 1, "hundredths count");
    bad = 0;
    for (int i = g0 + 1; i < gaps.size(); i++)
    begin
      bad += int'(gaps[i] != 512 && gaps[i] != 768);
      bad += int'((hv[i] - hv[i-1] + 100) % 100 != 1);
      sum = 0;
      for (int j = i - 24; j <= i && i >= g0 + 25; j++)
        sum += gaps[j];
      bad += int'(i >= g0 + 25 && sum != 16384);
    end
    chk_cnt(bad, 0, "hundredths pacing");
    // Periodic pulse keeps coming while time counting is stopped
    stop = 1'b1;
    tick(3);
    h0 = gaps.size();
    s0 = n_s;
    p0 = n_p;
    for (int k = 0; k < 70000 && n_p == p0; k++)
      @(negedge clk);
    chk_cnt(n_p - p0, 1, "periodic stopped");
    chk_cnt(int'(last_p - en_cyc <= 65540), 1, "first pulse");
    chk_cnt(gaps.size() - h0 + n_s - s0, 0, "ticks stopped");
    chk_cnt(n_fl, 0, "flag set");
    end_sim();
  end
endmodule

`default_nettype wire
